// ---- hw/cls_defs.vh ----
`ifndef CLS_DEFS_VH
`define CLS_DEFS_VH

// register byte offsets
`define CLS_REG_CTRL 5'h00
`define CLS_REG_TABLE0 5'h04
`define CLS_REG_TABLE1 5'h08
`define CLS_REG_STATUS 5'h0C

// control register fields
`define CLS_CTRL_MODE_LSB 0
`define CLS_CTRL_MODE_MSB 1
`define CLS_CTRL_FN_LSB 2
`define CLS_CTRL_FN_MSB 5
`define CLS_CTRL_PRESET0 6
`define CLS_CTRL_PRESET1 7
`define CLS_CTRL_RST 8'h00

// status register fields
`define CLS_ST_BYPASS0 0
`define CLS_ST_BYPASS1 1
`define CLS_ST_REG0 2
`define CLS_ST_REG1 3
`define CLS_ST_FIVE 4
`define CLS_ST_CARRY 5
`define CLS_ST_GEN 6
`define CLS_ST_PROP 7
`define CLS_ST_REFUSED 8
`define CLS_ST_MEMCAP 9

// operating modes
`define CLS_MODE_LOGIC 2'h0
`define CLS_MODE_RIPPLE 2'h1
`define CLS_MODE_RAM 2'h2
`define CLS_MODE_ROM 2'h3

// ripple functions
`define CLS_FN_ADD 4'h0
`define CLS_FN_SUB 4'h1
`define CLS_FN_ADDSUB 4'h2
`define CLS_FN_UP 4'h3
`define CLS_FN_DOWN 4'h4
`define CLS_FN_GE 4'h5
`define CLS_FN_NE 4'h6
`define CLS_FN_LE 4'h7
`define CLS_FN_MULT 4'h8

// table geometry and reset content
`define CLS_TABLE_DEPTH 16
`define CLS_TABLE_AW 4
`define CLS_TABLE_RST 16'h0000

`endif

// ---- hw/cls_table_mem.v ----
`timescale 1ns/100ps
`include "cls_defs.vh"

// one sixteen-entry by one-bit table; contents live in flops so the
// whole word is visible at once for a combinational lookup
module cls_table_mem #(
    parameter DEPTH = `CLS_TABLE_DEPTH,
    parameter AW = `CLS_TABLE_AW
) (
    input wire clk_sys,
    input wire nrst,
    input wire cfg_we,
    input wire [DEPTH-1:0] cfg_data,
    input wire bit_we,
    input wire [AW-1:0] bit_addr,
    input wire bit_data,
    output reg [DEPTH-1:0] contents_q
);

    reg [DEPTH-1:0] contents_d;

    always @* begin
        contents_d = contents_q;
        // a bus load beats a fabric write in the same cycle
        if (cfg_we) begin
            contents_d = cfg_data;
        end else if (bit_we) begin
            contents_d[bit_addr] = bit_data;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            contents_q <= `CLS_TABLE_RST;
        end else begin
            contents_q <= contents_d;
        end
    end

endmodule // cls_table_mem

// ---- hw/cls_slice.v ----
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "cls_defs.vh"

// How it works
// - mode field picks logic, ripple, distributed RAM or ROM behaviour.
// - with MEM_CAPABLE clear, RAM mode is refused and fabric table writes blocked; bus loads still work.
// - each table output is its programmed bit selected by four inputs.
// - multipurpose input zero picks between the two tables: five-input output.
// - multipurpose input one picks between neighbour five-input outputs.
// - ripple adds, subtracts, dynamic add/subtract, counts up or down.
// - ripple compares A with B (ge, ne, le) and gives a multiplier step.
// - ripple drives carry-generate and carry-propagate for the slice.
// - carry enters on the chain input and leaves on the chain output.
// - RAM mode writes each table as a 16x1 memory, 16x2 per slice.
// - ROM mode reads two independent configuration-loaded 16x1 tables.
// - tile of four gives eight tables down to one seven-input function.
// - separate write address lets slices pair into dual-port memories.
// - outside ripple mode, each table output appears raw and through a slice register.
module cls_slice #(
    parameter MEM_CAPABLE = 1
) (
    input wire clk_sys,
    input wire nrst,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [3:0] table_in0,
    input wire [3:0] table_in1,
    input wire multipurpose_input_zero,
    input wire multipurpose_input_one,
    input wire wide_in0,
    input wire wide_in1,
    input wire clk_en,
    input wire local_set_clear,
    input wire carry_chain_input,
    input wire ram_we,
    input wire [3:0] ram_wr_addr,
    input wire [1:0] ram_wr_data,
    output wire [1:0] table_bypass_outputs,
    output reg [1:0] registered_outputs,
    output wire five_input_mux_output,
    output wire wide_mux_output,
    output wire carry_chain_output,
    output wire carry_generate,
    output wire carry_propagate
);

    localparam TW = `CLS_TABLE_DEPTH;

    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg refused_q;
    reg refused_d;
    reg ack_q;
    reg [31:0] rdata_d;
    reg [1:0] regs_d;
    wire [TW-1:0] table_word [0:1];
    wire [3:0] table_addr [0:1];
    wire [1:0] table_out;
    wire [1:0] mode;
    wire [3:0] arith_fn;
    wire req;
    wire wr_fire;
    wire ram_active;

    assign mode = ctrl_q[`CLS_CTRL_MODE_MSB:`CLS_CTRL_MODE_LSB];
    assign arith_fn = ctrl_q[`CLS_CTRL_FN_MSB:`CLS_CTRL_FN_LSB];

    // one wait cycle per access: read data are captured while waiting,
    // so they stand at the edge where waitrequest is low
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_fire = avs_write & ack_q;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // a logic-only slice has no fabric (ram_we) write path into its tables
    assign ram_active = (MEM_CAPABLE != 0) && (mode == `CLS_MODE_RAM);

    // table storage and the combinational lookup
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_table
            wire cfg_we;
            assign cfg_we = wr_fire
                && (avs_address == ((gi == 0) ? `CLS_REG_TABLE0
                                              : `CLS_REG_TABLE1));
            cls_table_mem #(
                .DEPTH(TW),
                .AW(`CLS_TABLE_AW)
            ) u_mem (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .cfg_we(cfg_we),
                .cfg_data(avs_writedata[TW-1:0]),
                .bit_we(ram_we & ram_active),
                .bit_addr(ram_wr_addr),
                .bit_data(ram_wr_data[gi]),
                .contents_q(table_word[gi])
            );
            assign table_addr[gi] = (gi == 0) ? table_in0 : table_in1;
            // read is a plain mux of stored bits, no clock in the path
            assign table_out[gi] = table_word[gi][table_addr[gi]];
        end
    endgenerate

    // five-input and wider functions
    assign five_input_mux_output = multipurpose_input_zero
        ? table_out[1] : table_out[0];
    assign wide_mux_output = multipurpose_input_one
        ? wide_in1 : wide_in0;

    // ripple datapath: A on input bit 0, B on input bit 1 of each table
    wire [1:0] op_a;
    wire [1:0] op_b;
    reg [1:0] op_x;
    reg [1:0] op_y;
    reg [1:0] ripple_f;
    reg ripple_co;
    reg ripple_g;
    reg ripple_p;
    reg [2:0] sum_c;
    reg [2:0] sum_g;

    assign op_a = {table_in1[0], table_in0[0]};
    assign op_b = {table_in1[1], table_in0[1]};

    always @* begin
        op_x = op_a;
        op_y = op_b;
        case (arith_fn)
            `CLS_FN_ADD: begin
                op_y = op_b;
            end
            `CLS_FN_SUB: begin
                op_y = ~op_b;
            end
            `CLS_FN_ADDSUB: begin
                // multipurpose input zero high selects subtract
                op_y = multipurpose_input_zero ? ~op_b : op_b;
            end
            `CLS_FN_UP: begin
                op_x = registered_outputs;
                op_y = 2'h0;
            end
            `CLS_FN_DOWN: begin
                op_x = registered_outputs;
                op_y = 2'h3;
            end
            `CLS_FN_GE: begin
                op_y = ~op_b;
            end
            `CLS_FN_LE: begin
                op_x = op_b;
                op_y = ~op_a;
            end
            `CLS_FN_MULT: begin
                // partial product step: B gated by the multiplier bit
                op_y = op_b & {2{multipurpose_input_one}};
            end
            default: begin
                op_y = op_b;
            end
        endcase
    end

    always @* begin
        sum_c = {1'b0, op_x} + {1'b0, op_y} + {2'h0, carry_chain_input};
        sum_g = {1'b0, op_x} + {1'b0, op_y};
        ripple_f = sum_c[1:0];
        ripple_co = sum_c[2];
        ripple_g = sum_g[2];
        ripple_p = &(op_x ^ op_y);
        case (arith_fn)
            `CLS_FN_GE, `CLS_FN_LE: begin
                // chain carry out is the compare result at the top slice
                ripple_f = {1'b0, sum_c[2]};
            end
            `CLS_FN_NE: begin
                ripple_co = carry_chain_input | (op_a != op_b);
                ripple_f = {1'b0, ripple_co};
                ripple_g = (op_a != op_b);
                ripple_p = ~ripple_g;
            end
            default: begin
                ripple_f = sum_c[1:0];
            end
        endcase
    end

    reg [1:0] bypass;
    reg chain_out;
    reg gen_out;
    reg prop_out;

    always @* begin
        bypass = table_out;
        chain_out = 1'b0;
        gen_out = 1'b0;
        prop_out = 1'b0;
        case (mode)
            `CLS_MODE_RIPPLE: begin
                bypass = ripple_f;
                chain_out = ripple_co;
                gen_out = ripple_g;
                prop_out = ripple_p;
            end
            `CLS_MODE_LOGIC, `CLS_MODE_RAM, `CLS_MODE_ROM: begin
                bypass = table_out;
            end
            default: begin
                bypass = table_out;
            end
        endcase
    end

    assign table_bypass_outputs = bypass;
    assign carry_chain_output = chain_out;
    assign carry_generate = gen_out;
    assign carry_propagate = prop_out;

    // slice registers: set/clear beats the clock enable
    always @* begin
        regs_d = registered_outputs;
        if (local_set_clear) begin
            regs_d = {ctrl_q[`CLS_CTRL_PRESET1],
                      ctrl_q[`CLS_CTRL_PRESET0]};
        end else if (clk_en) begin
            regs_d = bypass;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            registered_outputs <= 2'h0;
        end else begin
            registered_outputs <= regs_d;
        end
    end

    // control register; a RAM request on a logic-only slice keeps the
    // old mode and raises a sticky flag instead
    always @* begin
        ctrl_d = ctrl_q;
        refused_d = refused_q;
        if (wr_fire && avs_address == `CLS_REG_CTRL) begin
            ctrl_d = avs_writedata[7:0];
            if ((MEM_CAPABLE == 0) && (avs_writedata[
                    `CLS_CTRL_MODE_MSB:`CLS_CTRL_MODE_LSB]
                    == `CLS_MODE_RAM)) begin
                ctrl_d[`CLS_CTRL_MODE_MSB:`CLS_CTRL_MODE_LSB] = mode;
                refused_d = 1'b1;
            end
        end else if (wr_fire && avs_address == `CLS_REG_STATUS
                     && avs_writedata[`CLS_ST_REFUSED]) begin
            refused_d = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q <= `CLS_CTRL_RST;
            refused_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            refused_q <= refused_d;
        end
    end

    // read data, captured on the waiting cycle
    always @* begin
        rdata_d = 32'h0;
        case (avs_address)
            `CLS_REG_CTRL: begin
                rdata_d[7:0] = ctrl_q;
            end
            `CLS_REG_TABLE0: begin
                rdata_d[TW-1:0] = table_word[0];
            end
            `CLS_REG_TABLE1: begin
                rdata_d[TW-1:0] = table_word[1];
            end
            `CLS_REG_STATUS: begin
                rdata_d[`CLS_ST_BYPASS0] = bypass[0];
                rdata_d[`CLS_ST_BYPASS1] = bypass[1];
                rdata_d[`CLS_ST_REG0] = registered_outputs[0];
                rdata_d[`CLS_ST_REG1] = registered_outputs[1];
                rdata_d[`CLS_ST_FIVE] = five_input_mux_output;
                rdata_d[`CLS_ST_CARRY] = chain_out;
                rdata_d[`CLS_ST_GEN] = gen_out;
                rdata_d[`CLS_ST_PROP] = prop_out;
                rdata_d[`CLS_ST_REFUSED] = refused_q;
                rdata_d[`CLS_ST_MEMCAP] = (MEM_CAPABLE != 0);
            end
            default: begin
                rdata_d = 32'h0;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rdata_d;
        end
    end

endmodule // cls_slice

// ---- tb/cls_fabric_model.sv ----
`timescale 1ns/100ps
// neighbours seen as plain logic: a preceding tile's carry-out and two
// adjacent five-input outputs, all same-clock and combinational
module cls_fabric_model (
    input wire nb_carry,
    input wire [1:0] nb_five,
    output wire carry_chain_input,
    output wire wide_in0,
    output wire wide_in1
);
    assign carry_chain_input = nb_carry;
    assign wide_in0 = nb_five[0];
    assign wide_in1 = nb_five[1];
endmodule // cls_fabric_model

// ---- tb/cls_slice_monitor.sv ----
`timescale 1ns/100ps
module cls_slice_mon (
    input wire clk_sys,
    input wire nrst,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire multipurpose_input_one,
    input wire wide_in0,
    input wire wide_in1,
    input wire clk_en,
    input wire local_set_clear,
    input wire carry_chain_input,
    input wire [1:0] table_bypass_outputs,
    input wire [1:0] registered_outputs,
    input wire wide_mux_output,
    input wire carry_chain_output,
    input wire carry_generate,
    input wire carry_propagate
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence one_wait_s;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence lsc_twice_s;
        local_set_clear ##1 local_set_clear;
    endsequence
    bus_wait_a: assert property (
        $rose(avs_read || avs_write) |-> one_wait_s)
        else $error("bus wait not one cycle");
    reg_load_a: assert property (clk_en && !local_set_clear |=>
        registered_outputs == $past(table_bypass_outputs))
        else $error("register did not load table output");
    reg_hold_a: assert property (
        !clk_en && !local_set_clear |=> $stable(registered_outputs))
        else $error("register moved without enable");
    preset_same_a: assert property (
        lsc_twice_s |=> $stable(registered_outputs))
        else $error("preset value not repeatable");
    gen_excl_a: assert property (
        !(carry_generate && carry_propagate))
        else $error("generate and propagate both high");
    gen_carry_a: assert property (
        carry_generate |-> carry_chain_output)
        else $error("generate without carry out");
    prop_pass_a: assert property (
        carry_propagate |-> carry_chain_output == carry_chain_input)
        else $error("propagate did not pass carry");
    wide_sel_a: assert property (wide_mux_output ==
        (multipurpose_input_one ? wide_in1 : wide_in0))
        else $error("wide mux selection wrong");
endmodule // cls_slice_mon

bind cls_slice cls_slice_mon u_cls_slice_mon (
    .clk_sys, .nrst, .avs_read, .avs_write, .avs_waitrequest,
    .multipurpose_input_one, .wide_in0, .wide_in1, .clk_en,
    .local_set_clear, .carry_chain_input, .table_bypass_outputs,
    .registered_outputs, .wide_mux_output, .carry_chain_output,
    .carry_generate, .carry_propagate
);

// ---- tb/cls_slice_tb.sv ----
`timescale 1ns/100ps
`include "cls_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cls_slice_tb;
    reg clk_sys, nrst, rd_q, wr_q, m0, m1, clk_en, lsc, nb_carry, ram_we;
    reg [4:0] addr;
    reg [31:0] wdata, rd, rd_lo;
    reg [3:0] tin0, tin1, ram_wr_addr;
    reg [1:0] ram_wr_data, nb_five;
    wire [31:0] rdata, rdata_lo;
    wire [1:0] byp, regq;
    wire waitreq, five, wide, cout, gen, prop, cin, w0, w1;
    integer n_fail = 0;
    integer n_tests = 0;
    integer i;
    reg [2:0] exp3;
    localparam [15:0] T0 = 16'hA5C3;
    localparam [15:0] T1 = 16'h1234;
    cls_fabric_model u_cls_fabric_model (.nb_carry(nb_carry),
        .nb_five(nb_five), .carry_chain_input(cin), .wide_in0(w0),
        .wide_in1(w1));
    cls_slice u_cls_slice (.clk_sys(clk_sys), .nrst(nrst),
        .avs_address(addr), .avs_read(rd_q), .avs_write(wr_q),
        .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .table_in0(tin0), .table_in1(tin1),
        .multipurpose_input_zero(m0), .multipurpose_input_one(m1),
        .wide_in0(w0), .wide_in1(w1), .clk_en(clk_en),
        .local_set_clear(lsc), .carry_chain_input(cin), .ram_we(ram_we),
        .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
        .table_bypass_outputs(byp), .registered_outputs(regq),
        .five_input_mux_output(five), .wide_mux_output(wide),
        .carry_chain_output(cout), .carry_generate(gen),
        .carry_propagate(prop));
    // logic-only twin on the same inputs, so its refusals can be seen
    cls_slice #(.MEM_CAPABLE(0)) u_cls_slice_lo (.clk_sys(clk_sys),
        .nrst(nrst), .avs_address(addr), .avs_read(rd_q),
        .avs_write(wr_q), .avs_writedata(wdata),
        .avs_readdata(rdata_lo), .avs_waitrequest(),
        .table_in0(tin0), .table_in1(tin1),
        .multipurpose_input_zero(m0), .multipurpose_input_one(m1),
        .wide_in0(w0), .wide_in1(w1), .clk_en(clk_en),
        .local_set_clear(lsc), .carry_chain_input(cin), .ram_we(ram_we),
        .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
        .table_bypass_outputs(), .registered_outputs(),
        .five_input_mux_output(), .wide_mux_output(),
        .carry_chain_output(), .carry_generate(),
        .carry_propagate());
    // expected {carry out, f1, f0} of one slice
    function [2:0] rip(input [3:0] fn, input [1:0] a, input [1:0] b,
        input [1:0] q, input c, input sub, input mb);
        reg [1:0] x;
        reg [1:0] y;
        reg [2:0] s;
        begin
            x = a;
            y = b;
            case (fn)
                `CLS_FN_SUB, `CLS_FN_GE: y = ~b;
                `CLS_FN_ADDSUB: y = sub ? ~b : b;
                `CLS_FN_UP: begin x = q; y = 2'h0; end
                `CLS_FN_DOWN: begin x = q; y = 2'h3; end
                `CLS_FN_LE: begin x = b; y = ~a; end
                `CLS_FN_MULT: y = b & {2{mb}};
                default: ;
            endcase
            s = x + y + c;
            rip = s;
            if (fn == `CLS_FN_GE || fn == `CLS_FN_LE)
                rip = {s[2], 1'b0, s[2]};
            if (fn == `CLS_FN_NE)
                rip = {c | (a != b), 1'b0, c | (a != b)};
        end
    endfunction
    task bus(input w, input [4:0] a, input [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_q <= w;
        rd_q <= !w;
        do @(posedge clk_sys); while (waitreq);
        rd = rdata;
        rd_lo = rdata_lo;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask
    task t_reset;
        bus(0, `CLS_REG_CTRL, 0);
        `CHK(rd, 32'h0)
        bus(0, `CLS_REG_STATUS, 0);
        `CHK(rd[9:8], 2'b10)
        `CHK(rd_lo[9:8], 2'b00)
        bus(0, 5'h10, 0);
        `CHK(rd, 32'h0)
    endtask
    task t_logic;
        bus(1, `CLS_REG_TABLE0, {16'h0, T0});
        bus(1, `CLS_REG_TABLE1, {16'h0, T1});
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            tin0 <= i[3:0];
            tin1 <= 4'hF - i[3:0];
            m0 <= i[0];
            m1 <= i[1];
            nb_five <= i[3:2];
            #2;
            `CHK(byp, {T1[15-i], T0[i]})
            `CHK(five, i[0] ? T1[15-i] : T0[i])
            `CHK(wide, nb_five[i[1]])
        end
    endtask
    task t_regs;
        bus(1, `CLS_REG_CTRL, 32'hC0);
        @(posedge clk_sys);
        lsc <= 1'b1;
        @(posedge clk_sys);
        // held for two edges: the preset must load the same value twice
        @(posedge clk_sys);
        lsc <= 1'b0;
        tin0 <= 4'h0;
        tin1 <= 4'h0;
        @(posedge clk_sys);
        #2;
        `CHK(regq, 2'b11)
        @(posedge clk_sys);
        clk_en <= 1'b1;
        @(posedge clk_sys);
        #2;
        `CHK(regq, {T1[0], T0[0]})
        @(posedge clk_sys);
        clk_en <= 1'b0;
    endtask
    task t_ripple;
        bus(1, `CLS_REG_CTRL, 32'h1);
        @(posedge clk_sys);
        lsc <= 1'b1;
        nb_carry <= 1'b1;
        tin0 <= 4'h2;
        tin1 <= 4'h3;
        m0 <= 1'b1;
        m1 <= 1'b1;
        @(posedge clk_sys);
        lsc <= 1'b0;
        for (i = 0; i < 9; i++) begin
            bus(1, `CLS_REG_CTRL, {26'h0, i[3:0], 2'h1});
            #2;
            exp3 = rip(i[3:0], 2'h2, 2'h3, 2'h0, 1'b1, 1'b1, 1'b1);
            `CHK({cout, byp}, exp3)
        end
        // add with A=1, B=2 only propagates; A=2, B=3 generates
        bus(1, `CLS_REG_CTRL, 32'h1);
        tin0 <= 4'h1;
        tin1 <= 4'h2;
        #2;
        `CHK({gen, prop, cout}, 3'b011)
        @(posedge clk_sys);
        tin0 <= 4'h2;
        tin1 <= 4'h3;
        #2;
        `CHK({gen, prop, cout}, 3'b101)
    endtask
    task t_ram;
        bus(1, `CLS_REG_CTRL, {30'h0, `CLS_MODE_RAM});
        @(posedge clk_sys);
        ram_we <= 1'b1;
        ram_wr_addr <= 4'h5;
        ram_wr_data <= 2'b01;
        @(posedge clk_sys);
        ram_wr_addr <= 4'h6;
        ram_wr_data <= 2'b10;
        @(posedge clk_sys);
        ram_we <= 1'b0;
        tin0 <= 4'h5;
        tin1 <= 4'h5;
        #2;
        `CHK(byp, 2'b01)
        bus(0, `CLS_REG_TABLE0, 0);
        `CHK(rd, 32'hA5A3)
        `CHK(rd_lo, 32'hA5C3)
        bus(0, `CLS_REG_TABLE1, 0);
        `CHK(rd, 32'h1254)
        `CHK(rd_lo, 32'h1234)
        bus(0, `CLS_REG_CTRL, 0);
        `CHK(rd, 32'h2)
        `CHK(rd_lo, 32'h1)
        bus(0, `CLS_REG_STATUS, 0);
        `CHK(rd_lo[9:8], 2'b01)
        bus(1, `CLS_REG_STATUS, 32'h100);
        bus(0, `CLS_REG_STATUS, 0);
        `CHK(rd_lo[9:8], 2'b00)
        bus(1, `CLS_REG_CTRL, {30'h0, `CLS_MODE_ROM});
        @(posedge clk_sys);
        ram_we <= 1'b1;
        ram_wr_data <= 2'b10;
        ram_wr_addr <= 4'h5;
        @(posedge clk_sys);
        ram_we <= 1'b0;
        #2;
        `CHK(byp, 2'b01)
    endtask
    task print_verdict;
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        {nrst, rd_q, wr_q, m0, m1, clk_en, lsc, nb_carry, ram_we} = 0;
        {addr, wdata, tin0, tin1, ram_wr_addr, ram_wr_data, nb_five} = 0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset;
        t_logic;
        t_regs;
        t_ripple;
        t_ram;
        print_verdict;
    end
    // whole run is under 120 cycles; this leaves wide margin
    initial begin
        #200000;
        n_fail++;
        print_verdict;
    end
endmodule // cls_slice_tb
